// File: hdl/pcmfs_top.sv
// PCM telemetry frame sequencer: timing chain, gate drive, SAR coder,
// output register, calibration monitor, format selector.
// Assumes comparator, pps and straps arrive asynchronously from pins.
//
// Contract
// - gate opens and closes within one word
// - drive level removed before transformer saturation
// - NRZ serial stream feeding two drivers
// - spare slots split high and low reference
// - high reference to 20, 25, 2 gates
// - amplifier reference high word 89, low 9
// - coder reference low word 9, high 89
// - calibration words checked at coder output
// - faults on magnitude and count per interval
// - successive approximation keeps or drops trial weights
// - optional clamp to codes 254 and 1
// - sync pattern in all 24 bits
// - sync complemented on alternate sub-frames
// - sync words set by configuration inputs
// - minimum frame lasts one second, one sync
// - format switch keeps word and frame counters
// - clamped amplifier unpowered in minimum format
// - other unused circuits powered down likewise
// - sub-frame of 160 words, 50 per second
// - divide to 1 per second, pps realigns
// - format change only at end of frame
// - minimum frame 200 words, sync then mode id
`timescale 1ns/1ps
module pcmfs_top
  import pcmfs_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        pps_in,
  input  wire logic        int_osc_in,
  input  wire logic        fmt_min_req_in,
  input  wire logic        clamp_en_in,
  input  wire logic        cmp_in,
  input  wire logic [23:0] sync_pat_in,
  output logic             gate_drive_out,
  output logic [7:0]       gate_sel_out,
  output logic             hold_out,
  output logic [7:0]       sar_trial_out,
  output logic             amp_ref_hi_out,
  output logic             amp_ref_lo_out,
  output logic             adc_ref_hi_out,
  output logic             adc_ref_lo_out,
  output logic [2:0]       grp_ref_hi_out,
  output logic             nrz_a_out,
  output logic             nrz_b_out,
  output logic             min_mode_out,
  output logic             amp_pwr_en_out,
  output logic             aux_pwr_en_out,
  output logic [1:0]       fault_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Distance between a code and its expected reference.
  function automatic logic [7:0] absdiff(input logic [7:0] a,
                                         input logic [7:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] pps_s_q, osc_s_q, req_s_q, clmp_s_q, cmp_s_q;
  logic       pps_old_q;

  // Two flops on the pps, oscillator, format, clamp and comparator pins before logic looks at them.
  // None of these flops is reset: they refill with pin levels within
  // two cycles, and reset is held far longer than that.
  always_ff @(posedge sys_clk_in) begin
    pps_s_q   <= {pps_s_q[0], pps_in};
    osc_s_q   <= {osc_s_q[0], int_osc_in};
    req_s_q   <= {req_s_q[0], fmt_min_req_in};
    clmp_s_q  <= {clmp_s_q[0], clamp_en_in};
    cmp_s_q   <= {cmp_s_q[0], cmp_in};
    pps_old_q <= pps_s_q[1];
  end

  // External pulse is ignored while the internal oscillator runs.
  wire pps_rise = pps_s_q[1] & ~pps_old_q & ~osc_s_q[1];

  // ****************************************************************
  // Timing chain: bit, word, sub-frame counters
  // ****************************************************************
  logic [11:0] bcyc_q;
  logic [2:0]  bpos_q;
  logic [7:0]  word_q;
  logic [5:0]  sub_q;

  // The bit period is a whole number of system cycles, so the word
  // rate runs a hair fast; the pulse once a second takes up the
  // slack.
  wire bit_tick  = (bcyc_q == 12'(BIT_CYC - 1));
  wire word_end  = bit_tick & (bpos_q == 3'd7);
  wire sub_end   = word_end & (word_q == 8'(WORDS_SUB - 1));
  wire frame_end = sub_end & (sub_q == 6'(SUBS_FRM - 1));

  // The chain never looks at the format, so switching cannot slip it.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || pps_rise) begin
      bcyc_q <= '0;
      bpos_q <= '0;
      word_q <= '0;
      sub_q  <= '0;
    end else begin
      bcyc_q <= bit_tick ? '0 : bcyc_q + 12'd1;
      if (bit_tick) bpos_q <= bpos_q + 3'd1;
      if (word_end) word_q <= sub_end ? '0 : word_q + 8'd1;
      if (sub_end) sub_q <= frame_end ? '0 : sub_q + 6'd1;
    end
  end

  // ****************************************************************
  // Gate drive and reference routing
  // ****************************************************************
  logic [15:0] gcnt_q;
  logic        wstart_q;

  wire gate_on = (gcnt_q < 16'(GATE_CYCLES));
  wire cal_w   = (word_q == W_CAL_LO) | (word_q == W_CAL_HI);
  wire hi_w    = (word_q == W_CAL_HI);

  // Drive falls before the core saturates and before the word ends.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      gcnt_q         <= '0;
      // Starting high makes the first word after reset convert too.
      wstart_q       <= 1'b1;
      gate_drive_out <= 1'b0;
      gate_sel_out   <= '0;
      amp_ref_hi_out <= 1'b0;
      amp_ref_lo_out <= 1'b0;
      adc_ref_hi_out <= 1'b0;
      adc_ref_lo_out <= 1'b0;
      grp_ref_hi_out <= '0;
    end else begin
      wstart_q       <= word_end;
      gcnt_q         <= word_end ? '0 : (gate_on ? gcnt_q + 16'd1 : gcnt_q);
      // The drive drops after GATE_CYCLES, below core saturation.
      gate_drive_out <= gate_on & ~word_end;
      gate_sel_out   <= word_q;
      amp_ref_hi_out <= (sub_q == SUB_AMP) & hi_w;
      amp_ref_lo_out <= (sub_q == SUB_AMP) & cal_w & ~hi_w;
      adc_ref_hi_out <= (sub_q == SUB_ADC) & hi_w;
      adc_ref_lo_out <= (sub_q == SUB_ADC) & cal_w & ~hi_w;
      // Spare slot index is the sub-frame; the rest see low.
      grp_ref_hi_out <= {sub_q < 6'(G5_HI), sub_q < 6'(G3_HI),
                         sub_q < G1_HI};
    end
  end

  // ****************************************************************
  // Successive approximation coder
  // ****************************************************************
  pcmfs_sar_t  sar_q;
  logic [3:0]  scnt_q;
  logic [2:0]  sbit_q;
  logic [7:0]  res_q;
  logic [7:0]  sword_q;
  logic [5:0]  ssub_q;

  // Sixteen cycles per trial leave room for the comparator's own
  // register plus the two synchroniser flops before each decision.
  wire step_end = (scnt_q == 4'(SAR_STEP - 1));
  wire [7:0] wt = 8'h01 << sbit_q;
  // Comparator high means the held sample is at or above the trial.
  wire [7:0] kept = cmp_s_q[1] ? sar_trial_out
                               : (sar_trial_out & ~wt);
  // Clamping touches the stored result only; the trial port shows the
  // raw code so the front end always sees the true balance point.
  wire [7:0] clamped = (clmp_s_q[1] && kept > CODE_MAX) ? CODE_MAX
                     : (clmp_s_q[1] && kept < CODE_MIN) ? CODE_MIN
                     : kept;

  // One conversion per word; its code goes out in the next word.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sar_q         <= PCMFS_IDLE;
      scnt_q        <= '0;
      sbit_q        <= '0;
      res_q         <= '0;
      sword_q       <= '0;
      ssub_q        <= '0;
      hold_out      <= 1'b0;
      sar_trial_out <= '0;
    end else begin
      scnt_q <= (sar_q != PCMFS_RUN || step_end) ? '0 : scnt_q + 4'd1;
      unique case (sar_q)
        PCMFS_IDLE, PCMFS_DONE: begin
          if (wstart_q) begin
            sar_q         <= PCMFS_RUN;
            sbit_q        <= 3'd7;
            sar_trial_out <= 8'h80;
            sword_q       <= word_q;
            ssub_q        <= sub_q;
            hold_out      <= 1'b1;
          end else if (sar_q == PCMFS_DONE) begin
            sar_q <= PCMFS_IDLE;
          end
        end
        PCMFS_RUN: begin
          if (step_end) begin
            if (sbit_q == 3'd0) begin
              sar_q         <= PCMFS_DONE;
              res_q         <= clamped;
              sar_trial_out <= kept;
              hold_out      <= 1'b0;
            end else begin
              sbit_q        <= sbit_q - 3'd1;
              sar_trial_out <= kept | (wt >> 1);
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Calibration monitor at the coder output
  // ****************************************************************
  logic [3:0] ecnt_q [2];

  // A check fires only on the DONE cycle, once per calibration word,
  // so each bad word is counted exactly once.
  wire chk = (sar_q == PCMFS_DONE)
           & ((sword_q == W_CAL_LO) | (sword_q == W_CAL_HI))
           & ((ssub_q == SUB_AMP) | (ssub_q == SUB_ADC));
  wire [7:0] exp_code = (sword_q == W_CAL_HI) ? REF_HI : REF_LO;
  wire bad = chk & (absdiff(res_q, exp_code) > ERR_MAG);
  wire mod = (ssub_q == SUB_ADC);

  // Counts restart each second; a raised fault holds until reset.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ecnt_q[0] <= '0;
      ecnt_q[1] <= '0;
      fault_out <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (frame_end) ecnt_q[i] <= '0;
        else if (bad && (mod == 1'(i)) && ecnt_q[i] != 4'hF)
          ecnt_q[i] <= ecnt_q[i] + 4'd1;
        if (ecnt_q[i] >= ERR_CNT) fault_out[i] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Format selector and power gating
  // ****************************************************************
  logic pend_q;
  logic pol_q;

  // Format word choice; a pin, so only the synchronised copy is read.
  wire [7:0] fword = req_s_q[1] ? FMT_MIN : FMT_NORM;

  // Takes the requested mode from the current format word choice as word
  // 122 of a sub-frame ends, then applies it only where the whole cycle closes.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pend_q         <= 1'b0;
      min_mode_out   <= 1'b0;
      amp_pwr_en_out <= 1'b1;
      aux_pwr_en_out <= 1'b1;
    end else begin
      if (word_end && word_q == W_FMT) pend_q <= (fword == FMT_MIN);
      if (frame_end) min_mode_out <= pend_q;
      // Power follows the mode one cycle late; the overlap is harmless
      // because the slow format only ever starts at a frame edge.
      amp_pwr_en_out <= ~min_mode_out;
      aux_pwr_en_out <= ~min_mode_out;
    end
  end

  // ****************************************************************
  // Output register
  // ****************************************************************
  logic [7:0] sreg_q;
  logic [5:0] sdiv_q;
  logic [7:0] mword_q;

  // Slow words sit at words 18, 58, 98 and 138, forty words apart.
  wire slow_slot = (word_q >= W_SLOW0)
                 && ((word_q - W_SLOW0) % 8'(SLOW_DIV) == 8'd0);
  wire n_load    = word_end & ~min_mode_out;
  wire m_load    = word_end & min_mode_out & slow_slot;
  wire n_next0   = sub_end;
  wire [7:0] nxt = (word_q == 8'(WORDS_SUB - 1)) ? 8'd0 : word_q + 8'd1;
  wire [7:0] mnx = (mword_q == 8'(WORDS_MIN - 1)) ? 8'd0 : mword_q + 8'd1;
  // The sync byte follows the word being loaded, not the one leaving.
  wire [1:0] sidx    = 2'(min_mode_out ? mnx : nxt);
  wire [7:0] sync_w  = 8'(sync_pat_in >> (8 * (2 - sidx)));
  // The first sync word of a sub-frame already has the new polarity.
  wire       pol_use = pol_q ^ (n_next0 & ~min_mode_out);
  wire [7:0] sync_x  = pol_use ? ~sync_w : sync_w;
  wire [7:0] n_word = (nxt < 8'd3) ? sync_x
                    : (nxt == W_FMT) ? fword : res_q;
  wire [7:0] m_word = (mnx < 8'd3) ? sync_x
                    : (mnx == 8'd3) ? fword : res_q;
  // In the slow format each bit stands forty fast bit times, which
  // divides the line rate while the commutator keeps its full pace.
  wire m_shift = bit_tick & (sdiv_q == 6'(SLOW_DIV - 1));

  // Slow bits last forty fast bits; the chain itself keeps its pace.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sreg_q    <= '0;
      sdiv_q    <= '0;
      mword_q   <= 8'(WORDS_MIN - 1);
      pol_q     <= 1'b0;
      nrz_a_out <= 1'b0;
      nrz_b_out <= 1'b0;
    end else begin
      if (frame_end && min_mode_out)
        pol_q <= ~pol_q;
      else if (n_next0 && !min_mode_out)
        pol_q <= ~pol_q;
      if (n_load) begin
        sreg_q <= n_word;
      end else if (m_load) begin
        sreg_q  <= m_word;
        mword_q <= mnx;
        sdiv_q  <= '0;
      end else if (min_mode_out ? m_shift : bit_tick) begin
        sreg_q <= {sreg_q[6:0], 1'b0};
      end
      if (bit_tick && !m_load)
        sdiv_q <= m_shift ? '0 : sdiv_q + 6'd1;
      nrz_a_out <= sreg_q[7];
      nrz_b_out <= sreg_q[7];
    end
  end

endmodule : pcmfs_top

// File: hdl/pcmfs_pkg.sv
// Constants shared by the telemetry frame sequencer.
// Assumes a single 250 MHz system clock and no software register map.
package pcmfs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ   = 250_000_000;
  localparam int unsigned MCLK_HZ  = 512_000;  // Master timing rate.
  localparam int unsigned BIT_HZ   = MCLK_HZ / 8;
  localparam int unsigned BIT_CYC  = CLK_HZ / BIT_HZ;
  localparam int unsigned WORD_HZ  = 8_000;
  localparam int unsigned WORD_CYC = CLK_HZ / WORD_HZ;
  localparam int unsigned GATE_NS  = 62_500;  // Gate drive pulse.
  localparam int unsigned GATE_CYC = (GATE_NS / 4);
  localparam int unsigned SAR_STEP = 16;      // Cycles per trial.

  // ****************************************************************
  // Frame layout (word indices are zero based)
  // ****************************************************************
  localparam int unsigned WORDS_SUB = 160;
  localparam int unsigned SUBS_FRM  = 50;
  localparam int unsigned WORDS_MIN = 200;
  localparam int unsigned SLOW_DIV  = 40;
  localparam logic [7:0]  W_CAL_LO  = 8'h08;  // Word 9.
  localparam logic [7:0]  W_CAL_HI  = 8'h58;  // Word 89.
  localparam logic [7:0]  W_FMT     = 8'h79;  // Word 122.
  localparam logic [7:0]  W_SLOW0   = 8'h11;  // Word 18.
  localparam logic [5:0]  SUB_AMP   = 6'h00;
  localparam logic [5:0]  SUB_ADC   = 6'h01;
  localparam logic [5:0]  G1_HI     = 6'h14;  // 20 spare gates.
  localparam int unsigned G3_HI     = 25;
  localparam int unsigned G5_HI     = 2;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [7:0]  CODE_MAX  = 8'hFE;
  localparam logic [7:0]  CODE_MIN  = 8'h01;
  localparam logic [7:0]  FMT_NORM  = 8'hA5;
  localparam logic [7:0]  FMT_MIN   = 8'h5A;
  localparam logic [7:0]  REF_HI    = 8'hF0;
  localparam logic [7:0]  REF_LO    = 8'h10;
  localparam logic [7:0]  ERR_MAG   = 8'h04;
  localparam logic [3:0]  ERR_CNT   = 4'h2;

  typedef enum logic [1:0] {
    PCMFS_IDLE = 2'b00,
    PCMFS_RUN  = 2'b01,
    PCMFS_DONE = 2'b11
  } pcmfs_sar_t;

endpackage : pcmfs_pkg

// File: tb/pcmfs_checker.sv
// Port assertions for the telemetry frame sequencer.
// Assumes binding into pcmfs_top, one clock and a synchronous reset.
`timescale 1ns/1ps
module pcmfs_checker
  import pcmfs_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC
) (
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       pps_in,
  input wire logic       int_osc_in,
  input wire logic       gate_drive_out,
  input wire logic [7:0] gate_sel_out,
  input wire logic       hold_out,
  input wire logic [7:0] sar_trial_out,
  input wire logic       amp_ref_lo_out,
  input wire logic       adc_ref_hi_out,
  input wire logic       nrz_a_out,
  input wire logic       nrz_b_out,
  input wire logic       min_mode_out,
  input wire logic       amp_pwr_en_out,
  input wire logic       aux_pwr_en_out,
  input wire logic [1:0] fault_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ****
  // Gate drive
  // ****
  // Counts high cycles; too long a pulse would saturate the drive core.
  logic [15:0] hi_cnt_q;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !gate_drive_out) begin
      hi_cnt_q <= 16'h0000;
    end else begin
      hi_cnt_q <= hi_cnt_q + 16'h0001;
    end
  end
  gate_len_a: assert property (
    $fell(gate_drive_out) |-> hi_cnt_q == 16'(GATE_CYCLES))
    else $error("gate pulse length wrong");
  sel_steady_a: assert property (
    gate_drive_out && $past(gate_drive_out, 2) |-> $stable(gate_sel_out))
    else $error("word index moved while gate open");
  sar_start_a: assert property (
    $rose(gate_drive_out) |-> ##[0:1] (hold_out && sar_trial_out == 8'h80))
    else $error("conversion did not start with top weight");
  // ****
  // Stream, references, power, faults and pulse alignment
  // ****
  dual_nrz_a: assert property (nrz_a_out == nrz_b_out)
    else $error("output drivers differ");
  amp_ref_a: assert property (
    $rose(amp_ref_lo_out) |-> ##[0:2] gate_sel_out == 8'h08)
    else $error("amplifier low reference in wrong word");
  adc_ref_a: assert property (
    $rose(adc_ref_hi_out) |-> ##[0:2] gate_sel_out == 8'h58)
    else $error("coder high reference in wrong word");
  pwr_follow_a: assert property (
    amp_pwr_en_out == !$past(min_mode_out) && aux_pwr_en_out == amp_pwr_en_out)
    else $error("power enable does not follow format");
  fault_hold_a: assert property (
    |fault_out |=> (fault_out & $past(fault_out)) == $past(fault_out))
    else $error("fault dropped without reset");
  pps_align_a: assert property (
    $rose(pps_in) && !int_osc_in |-> ##[2:8] gate_sel_out == 8'h00)
    else $error("pulse did not realign word count");
  pps_ignore_a: assert property (
    $rose(pps_in) && int_osc_in && gate_sel_out != 8'h00 |->
      ##8 gate_sel_out != 8'h00)
    else $error("pulse not ignored on internal oscillator");
  cover property ($fell(gate_drive_out));
  cover property ($fell(hold_out));
  cover property ($rose(pps_in) && !int_osc_in);
endmodule : pcmfs_checker

bind pcmfs_top pcmfs_checker #(.GATE_CYCLES(GATE_CYCLES)) i_chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .pps_in(pps_in),
  .int_osc_in(int_osc_in), .gate_drive_out(gate_drive_out),
  .gate_sel_out(gate_sel_out), .hold_out(hold_out),
  .sar_trial_out(sar_trial_out), .amp_ref_lo_out(amp_ref_lo_out),
  .adc_ref_hi_out(adc_ref_hi_out), .nrz_a_out(nrz_a_out),
  .nrz_b_out(nrz_b_out), .min_mode_out(min_mode_out),
  .amp_pwr_en_out(amp_pwr_en_out), .aux_pwr_en_out(aux_pwr_en_out),
  .fault_out(fault_out));

// File: tb/pcmfs_front_model.sv
// Analog front end seen by the coder: a held sample and a comparator.
// Assumes the bench sets the sample before each conversion starts.
`timescale 1ns/1ps
module pcmfs_front_model (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] sample_in,
  input  wire logic [7:0] trial_in,
  output logic            cmp_out
);
  // Registered like a real comparator, so the coder must wait for it.
  always_ff @(posedge sys_clk_in) begin
    cmp_out <= (sample_in >= trial_in);
  end
endmodule : pcmfs_front_model

// File: tb/testbench.sv
// Self-checking bench for the telemetry frame sequencer.
// Assumes a short gate pulse parameter; full bit timing is kept.
`timescale 1ns/1ps
module testbench
  import pcmfs_pkg::*;
;
  localparam int unsigned GC = 50;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, pps_in = 1'b0;
  logic int_osc_in = 1'b0, fmt_min_req_in = 1'b0, clamp_en_in = 1'b0;
  logic [23:0] sync_pat_q = 24'h9F_35C2;
  logic [7:0] sample_q = 8'h00;
  logic cmp_in, gate_drive_out, hold_out, nrz_a_out, nrz_b_out;
  logic amp_ref_hi_out, amp_ref_lo_out, adc_ref_hi_out, adc_ref_lo_out;
  logic min_mode_out, amp_pwr_en_out, aux_pwr_en_out;
  logic [7:0] gate_sel_out, sar_trial_out;
  logic [2:0] grp_ref_hi_out;
  logic [1:0] fault_out;
  int errors = 0, cmp_count = 0;
  pcmfs_top #(.GATE_CYCLES(GC)) i_dut (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .pps_in(pps_in), .int_osc_in(int_osc_in),
    .fmt_min_req_in(fmt_min_req_in), .clamp_en_in(clamp_en_in),
    .cmp_in(cmp_in), .sync_pat_in(sync_pat_q),
    .gate_drive_out(gate_drive_out), .gate_sel_out(gate_sel_out),
    .hold_out(hold_out), .sar_trial_out(sar_trial_out),
    .amp_ref_hi_out(amp_ref_hi_out), .amp_ref_lo_out(amp_ref_lo_out),
    .adc_ref_hi_out(adc_ref_hi_out), .adc_ref_lo_out(adc_ref_lo_out),
    .grp_ref_hi_out(grp_ref_hi_out), .nrz_a_out(nrz_a_out),
    .nrz_b_out(nrz_b_out), .min_mode_out(min_mode_out),
    .amp_pwr_en_out(amp_pwr_en_out), .aux_pwr_en_out(aux_pwr_en_out),
    .fault_out(fault_out));
  pcmfs_front_model i_front (.sys_clk_in(sys_clk_in),
    .sample_in(sample_q), .trial_in(sar_trial_out), .cmp_out(cmp_in));
  // 4 ns period.
  always #2 sys_clk_in = ~sys_clk_in;
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Sample one ns after the edge so registered outputs have settled.
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic wait_sel(input logic [7:0] idx);
    int n;
    n = 0;
    while (gate_sel_out !== idx && n < 70000) begin
      tick();
      n++;
    end
    chk(24'(gate_sel_out), 24'(idx));
  endtask : wait_sel
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // ****
  // Scenarios
  // ****
  task automatic t_reset_vals();
    chk(24'({gate_drive_out, hold_out}), 24'h00_0000);
    chk(24'({nrz_a_out, fault_out}), 24'h00_0000);
    chk(24'({amp_pwr_en_out, aux_pwr_en_out}), 24'h00_0003);
  endtask : t_reset_vals
  // One conversion: gate pulse length, then the kept code.
  task automatic t_sar(input logic [7:0] s);
    int n;
    @(posedge sys_clk_in);
    sample_q <= s;
    #1;
    n = 0;
    while (gate_drive_out !== 1'b1 && n < 40000) begin
      tick();
      n++;
    end
    n = 0;
    while (gate_drive_out === 1'b1 && n < 40000) begin
      tick();
      n++;
    end
    chk(24'(n), 24'(GC));
    n = 0;
    while (hold_out === 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    chk(24'(sar_trial_out), 24'(s));
  endtask : t_sar
  // Word 2 of the frame carries the middle sync byte, MSB first.
  task automatic t_sync();
    logic b;
    wait_sel(8'h01);
    chk(24'(grp_ref_hi_out), 24'h00_0007);
    chk(24'({amp_ref_hi_out, adc_ref_lo_out}), 24'h00_0000);
    chk(24'({min_mode_out, aux_pwr_en_out}), 24'h00_0001);
    repeat (BIT_CYC / 2 - 2) @(posedge sys_clk_in);
    for (int k = 7; k >= 0; k--) begin
      if (k < 7) begin
        repeat (BIT_CYC) @(posedge sys_clk_in);
      end
      #1;
      b = sync_pat_q[8 + k];
      chk(24'(nrz_a_out), 24'(b));
      chk(24'(nrz_b_out), 24'(b));
    end
  endtask : t_sync
  // The pulse is ignored on the internal oscillator, else it realigns.
  task automatic t_pps(input logic osc, input logic [7:0] exp);
    @(posedge sys_clk_in);
    int_osc_in <= osc;
    repeat (4) @(posedge sys_clk_in);
    pps_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    pps_in <= 1'b0;
    repeat (8) tick();
    chk(24'(gate_sel_out), 24'(exp));
  endtask : t_pps
  initial begin : watchdog
    // The scenarios need about three words, some 94,000 cycles.
    repeat (99000) @(posedge sys_clk_in);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) tick();
    t_reset_vals();
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_sar(8'h00);
    t_sync();
    clamp_en_in <= 1'b1;
    t_sar(8'hFF);
    t_pps(1'b1, 8'h02);
    t_pps(1'b0, 8'h00);
    t_sar(8'h6B);
    tally_and_finish();
  end
endmodule : testbench
